// ---- inc/wdt_pkg.sv ----
// Purpose: shared constants and types of the watchdog reset timer
// Assumes: APB byte address is four times the register index
// Notes: the oscillator clock is taken to be pclk
package wdt_pkg;
    // register indices and byte addresses
    localparam int WDT_AW = 18;
    localparam logic [15:0] WDT_IDX_CSR = 16'hFFBE;
    localparam logic [15:0] WDT_IDX_CNT = 16'hFFBF;
    localparam logic [WDT_AW-1:0] WDT_ADDR_CSR = {WDT_IDX_CSR, 2'h0};
    localparam logic [WDT_AW-1:0] WDT_ADDR_CNT = {WDT_IDX_CNT, 2'h0};
    // control/status field positions
    localparam int WDT_BIT_FLAG = 0;
    localparam int WDT_BIT_FLAG_GUARD = 1;
    localparam int WDT_BIT_RUN = 2;
    localparam int WDT_BIT_RUN_GUARD = 3;
    localparam int WDT_BIT_REG_WEN = 4;
    localparam int WDT_BIT_REG_GUARD = 5;
    localparam int WDT_BIT_CNT_WEN = 6;
    localparam int WDT_BIT_CNT_GUARD = 7;
    // reset values and masks
    localparam logic [7:0] WDT_CSR_RESET = 8'hAA;
    localparam logic [7:0] WDT_GUARD_MASK = 8'hAA;
    localparam logic [7:0] WDT_CNT_RESET = 8'h00;
    localparam logic [7:0] WDT_CNT_MAX = 8'hFF;
    // timing: clock rate, prescaler ratio, reset length in oscillator cycles
    localparam int WDT_CLK_HZ = 10_000_000;
    localparam int WDT_PRESCALE = 8192;
    localparam int WDT_RESET_OSC_CYCLES = 512;
    localparam int WDT_RESET_CYCLES = WDT_RESET_OSC_CYCLES;
    // writable state of the control/status register
    typedef struct packed {
        logic count_write_en;
        logic reg_write_en;
        logic wdt_run;
        logic overflow_reset_flag;
    } wdt_csr_t;
endpackage

// ---- hw/wdt_timer.sv ----
// Purpose: watchdog reset timer with APB register access
// Assumes: pclk 10 MHz doubles as the oscillator clock; inputs synchronous
// Notes: presetn is the external reset pin; wdt_reset_n is the internal reset
`timescale 1ns/1ps

// Operation
// - 8-bit up-counter advances once per system clock divided by 8192
// - wrap from FF to 00 fires internal chip reset and sets overflow flag
// - internal reset stays asserted for 512 oscillator cycles
// - software counter write loads value, counting continues from it
// - count write enable bit 6 gates counter writes, resets to 0
// - guard bits 7, 5, 3, 1 always read 1, never stored
// - bits 6, 4, 2, 0 change only if guard above written 0 same write
// - register write enable bit 4 gates writes to bits 2 and 0
// - run sets when register write enable already 1 and write has guard 0, run 1
// - run clears on any reset or enabled write with guard 0, run 0
// - counter advances only while run is 1
// - overflow flag clears on pin reset or enabled write of 0 to bits 1, 0
// - chip reset clears counter and bits 6, 4, 2, keeps overflow flag; low-power modes halt counter, keep state
module wdt_timer
    import wdt_pkg::*;
#(
    parameter int PRESCALE = WDT_PRESCALE,
    parameter int RESET_CYCLES = WDT_RESET_CYCLES
) (
    // clock and external pin reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [WDT_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // chip power state: high in watch, subactive, subsleep and standby
    input wire logic halt_mode,
    // internal chip reset
    output logic wdt_reset_n
);
    localparam int PW = $clog2(PRESCALE);
    localparam int RW = $clog2(RESET_CYCLES);

    wdt_csr_t csr;
    logic count_write_en;
    logic reg_write_en;
    logic wdt_run;
    logic overflow_reset_flag;
    logic [7:0] wdt_counter;
    logic [PW-1:0] presc;
    logic [RW-1:0] rst_cnt;
    logic setup;
    logic wr;
    logic hit_csr;
    logic hit_cnt;
    logic tick;
    logic overflow;
    logic cnt_wr;
    logic csr_wr;
    logic [7:0] wd;

    // guarded field update: new value only when allowed and guard written 0
    function automatic logic guarded(input logic cur, input logic nv,
                                     input logic guard_bit, input logic allow);
        guarded = (allow && !guard_bit) ? nv : cur;
    endfunction

    // assembled read value of the control/status register
    function automatic logic [7:0] csr_value(input wdt_csr_t c);
        logic [7:0] v;
        v = WDT_GUARD_MASK;
        v[WDT_BIT_CNT_WEN] = c.count_write_en;
        v[WDT_BIT_REG_WEN] = c.reg_write_en;
        v[WDT_BIT_RUN] = c.wdt_run;
        v[WDT_BIT_FLAG] = c.overflow_reset_flag;
        csr_value = v;
    endfunction

    // bus decode; writes land at the access edge with pready high
    assign setup = psel && !penable;
    assign wr = psel && penable && pready && pwrite && wdt_reset_n;
    assign hit_csr = (paddr == WDT_ADDR_CSR);
    assign hit_cnt = (paddr == WDT_ADDR_CNT);
    assign wd = pwdata[7:0];
    assign csr_wr = wr && hit_csr;
    assign cnt_wr = wr && hit_cnt && csr.count_write_en;

    // one flop per field, assembled here so no field has two driving processes
    assign csr = '{count_write_en, reg_write_en, wdt_run, overflow_reset_flag};

    // prescaled tick, stopped by run off, low-power modes and internal reset
    assign tick = csr.wdt_run && !halt_mode && wdt_reset_n
                  && (presc == PW'(PRESCALE - 1));
    assign overflow = tick && !cnt_wr && (wdt_counter == WDT_CNT_MAX);

    // apb answer: one access cycle, no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup && !(hit_csr || hit_cnt);
        end
    end

    // read data captured in the setup cycle; reads never disturb state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            if (hit_csr) begin
                prdata <= {24'h00_0000, csr_value(csr)};
            end else if (hit_cnt) begin
                prdata <= {24'h00_0000, wdt_counter};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // prescaler; cleared on counter load so the full period follows
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc <= '0;
        end else if (!wdt_reset_n || !csr.wdt_run || cnt_wr) begin
            presc <= '0;
        end else if (!halt_mode) begin
            presc <= (presc == PW'(PRESCALE - 1)) ? '0 : presc + PW'(1);
        end
    end

    // counter; a software load beats a same-cycle increment
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_counter <= WDT_CNT_RESET;
        end else if (overflow || !wdt_reset_n) begin
            wdt_counter <= WDT_CNT_RESET;
        end else if (cnt_wr) begin
            wdt_counter <= wd;
        end else if (tick) begin
            wdt_counter <= wdt_counter + 8'h01;
        end
    end

    // internal reset pulse, counted in oscillator cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_reset_n <= 1'b1;
            rst_cnt <= '0;
        end else if (overflow) begin
            wdt_reset_n <= 1'b0;
            rst_cnt <= RW'(RESET_CYCLES - 1);
        end else if (!wdt_reset_n) begin
            if (rst_cnt == '0) begin
                wdt_reset_n <= 1'b1;
            end else begin
                rst_cnt <= rst_cnt - RW'(1);
            end
        end
    end

    // enables and run bit; guard bits are never stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_write_en <= 1'b0;
            reg_write_en <= 1'b0;
            wdt_run <= 1'b0;
        end else if (overflow || !wdt_reset_n) begin
            count_write_en <= 1'b0;
            reg_write_en <= 1'b0;
            wdt_run <= 1'b0;
        end else if (csr_wr) begin
            count_write_en <= guarded(count_write_en, wd[WDT_BIT_CNT_WEN],
                                      wd[WDT_BIT_CNT_GUARD], 1'b1);
            reg_write_en <= guarded(reg_write_en, wd[WDT_BIT_REG_WEN],
                                    wd[WDT_BIT_REG_GUARD], 1'b1);
            wdt_run <= guarded(wdt_run, wd[WDT_BIT_RUN],
                               wd[WDT_BIT_RUN_GUARD],
                               reg_write_en);
        end
    end

    // overflow flag: pin reset or enabled write of 0 to bits 1, 0 clears it; setting wins over a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_reset_flag <= 1'b0;
        end else if (overflow) begin
            overflow_reset_flag <= 1'b1;
        end else if (csr_wr && csr.reg_write_en && !wd[WDT_BIT_FLAG_GUARD]
                     && !wd[WDT_BIT_FLAG]) begin
            overflow_reset_flag <= 1'b0;
        end
    end

    // checking helpers: length of the current internal reset pulse
    logic [RW:0] low_len;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_len <= '0;
        end else if (!wdt_reset_n) begin
            low_len <= low_len + (RW + 1)'(1);
        end else begin
            low_len <= '0;
        end
    end

    sequence s_csr_write(logic [1:0] pair);
        csr_wr && csr.reg_write_en && wd[WDT_BIT_RUN_GUARD:WDT_BIT_RUN] == pair;
    endsequence

    sequence s_enter_reset;
        !wdt_reset_n && csr.overflow_reset_flag && wdt_counter == WDT_CNT_RESET;
    endsequence

    property p_overflow;
        @(posedge pclk) disable iff (!presetn)
        overflow |=> s_enter_reset;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow did not reset");

    property p_reset_len;
        @(posedge pclk) disable iff (!presetn)
        $rose(wdt_reset_n) |-> low_len == (RW + 1)'(RESET_CYCLES);
    endproperty
    a_reset_len: assert property (p_reset_len) else $error("reset pulse length wrong");

    property p_count_step;
        @(posedge pclk) disable iff (!presetn)
        tick && !cnt_wr && wdt_counter != WDT_CNT_MAX
            |=> wdt_counter == $past(wdt_counter) + 8'h01;
    endproperty
    a_count_step: assert property (p_count_step) else $error("counter did not step");

    property p_count_load;
        @(posedge pclk) disable iff (!presetn)
        wr && hit_cnt && csr.count_write_en |=> wdt_counter == $past(wd);
    endproperty
    a_count_load: assert property (p_count_load) else $error("counter load lost");

    property p_count_idle;
        @(posedge pclk) disable iff (!presetn)
        (!csr.wdt_run || halt_mode || (wr && hit_cnt && !csr.count_write_en && !tick))
            && !cnt_wr && wdt_reset_n |=> $stable(wdt_counter);
    endproperty
    a_count_idle: assert property (p_count_idle) else $error("counter moved");

    property p_guard_read;
        @(posedge pclk) disable iff (!presetn)
        psel && penable && pready && !pwrite && hit_csr
            |-> (prdata[7:0] & WDT_GUARD_MASK) == WDT_GUARD_MASK;
    endproperty
    a_guard_read: assert property (p_guard_read) else $error("guard bit read 0");

    property p_run_set;
        @(posedge pclk) disable iff (!presetn)
        s_csr_write(2'b01) |=> csr.wdt_run || !wdt_reset_n;
    endproperty
    a_run_set: assert property (p_run_set) else $error("run did not set");

    property p_run_clear;
        @(posedge pclk) disable iff (!presetn)
        s_csr_write(2'b00) |=> !csr.wdt_run;
    endproperty
    a_run_clear: assert property (p_run_clear) else $error("run did not clear");

    property p_guarded_hold;
        @(posedge pclk) disable iff (!presetn)
        csr_wr && wd[WDT_BIT_REG_GUARD] && !overflow |=> $stable(csr.reg_write_en);
    endproperty
    a_guarded_hold: assert property (p_guarded_hold) else $error("guarded bit changed");

    property p_run_locked;
        @(posedge pclk) disable iff (!presetn)
        csr_wr && !csr.reg_write_en && !overflow |=> $stable(csr.wdt_run);
    endproperty
    a_run_locked: assert property (p_run_locked) else $error("run changed when locked");

    property p_flag_clear;
        @(posedge pclk) disable iff (!presetn)
        csr_wr && csr.reg_write_en && wd[1:0] == 2'b00 && !overflow
            |=> !csr.overflow_reset_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

    property p_flag_kept;
        @(posedge pclk) disable iff (!presetn)
        !wdt_reset_n |-> csr.overflow_reset_flag;
    endproperty
    a_flag_kept: assert property (p_flag_kept) else $error("flag lost in reset");

    property p_halt;
        @(posedge pclk) disable iff (!presetn)
        halt_mode && !wr |=> $stable(csr) && $stable(wdt_counter);
    endproperty
    a_halt: assert property (p_halt) else $error("state moved in halt");

    // bus answer and register-state checks
    sequence s_read_done;
        psel && penable && pready && !pwrite;
    endsequence

    property p_answer_pulse;
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready;
    endproperty
    a_answer_pulse: assert property (p_answer_pulse) else $error("pready held too long");

    property p_err_with_ready;
        @(posedge pclk) disable iff (!presetn)
        pslverr |-> pready;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("error without answer");

    property p_read_upper;
        @(posedge pclk) disable iff (!presetn)
        s_read_done |-> prdata[31:8] == 24'h00_0000;
    endproperty
    a_read_upper: assert property (p_read_upper) else $error("upper read bits set");

    property p_read_hold;
        @(posedge pclk) disable iff (!presetn)
        !(setup && !pwrite) |=> $stable(prdata);
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("read data moved");

    property p_reset_clears;
        @(posedge pclk) disable iff (!presetn)
        !wdt_reset_n |-> wdt_counter == WDT_CNT_RESET && !csr.wdt_run
            && !csr.reg_write_en && !csr.count_write_en;
    endproperty
    a_reset_clears: assert property (p_reset_clears) else $error("state kept");

    property p_cnt_wen_hold;
        @(posedge pclk) disable iff (!presetn)
        csr_wr && wd[WDT_BIT_CNT_GUARD] && !overflow |=> $stable(csr.count_write_en);
    endproperty
    a_cnt_wen_hold: assert property (p_cnt_wen_hold) else $error("enable changed");

    property p_flag_guarded;
        @(posedge pclk) disable iff (!presetn)
        csr_wr && wd[WDT_BIT_FLAG_GUARD] && !overflow |=> $stable(csr.overflow_reset_flag);
    endproperty
    a_flag_guarded: assert property (p_flag_guarded) else $error("flag changed");

endmodule // wdt_timer

// ---- testbench/wdt_tb.sv ----
// Purpose: self-checking bench for the watchdog reset timer over apb
// Assumes: prescaler and reset length shortened to 8 cycles each
// Notes: register reads are checked by a monitor against a queue of notes
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_fail++; \
    $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); end end

module tb;
    import wdt_pkg::*;
    localparam int PS = 8;
    localparam int RC = 8;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic halt_mode = 0;
    logic [WDT_AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic wdt_reset_n;
    logic [32:0] exp_q[$];
    logic [32:0] mon_exp;
    logic [7:0] seed = 8'h48;
    logic [7:0] v;
    int n_fail = 0;
    int n_tests = 0;
    int cnt;

    // free-running system clock, 100 ns period
    initial forever #50 pclk = ~pclk;

    wdt_timer #(.PRESCALE(PS), .RESET_CYCLES(RC)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .halt_mode(halt_mode),
        .wdt_reset_n(wdt_reset_n)
    );

    // pseudo-random byte source, seeded with a fixed start value
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic wrap_up;
        // a note left unanswered means a read never completed
        if (exp_q.size() != 0) n_fail++;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // one apb transfer; an idle edge follows so strobes never toggle twice in a step
    task automatic apb(input logic [WDT_AW-1:0] a, input logic w, input logic [7:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            n_fail++;
            wrap_up();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [WDT_AW-1:0] a, input logic [7:0] d);
        apb(a, 1'b1, d);
    endtask

    // the expected error bit and byte are noted before the read is issued
    task automatic rd(input logic [WDT_AW-1:0] a, input logic [7:0] e, input logic err = 1'b0);
        exp_q.push_back({err, 24'h0, e});
        apb(a, 1'b0, 8'h00);
    endtask

    // monitor: each completed read takes the oldest note off the queue
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            if (exp_q.size() == 0) begin
                n_fail++;
                $display("CHECK FAILED at %0t: read with no expectation", $time);
            end else begin
                mon_exp = exp_q.pop_front();
                `CHK({pslverr, prdata}, mon_exp)
            end
        end
    end

    // main sequence
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(WDT_ADDR_CSR, WDT_CSR_RESET);
        rd(WDT_ADDR_CNT, WDT_CNT_RESET);
        rd(WDT_ADDR_CSR + 18'h8, 8'h00, 1'b1);
        wr(WDT_ADDR_CNT, 8'h55);
        rd(WDT_ADDR_CNT, 8'h00);
        wr(WDT_ADDR_CSR, 8'hC0);
        rd(WDT_ADDR_CSR, 8'hAA);
        wr(WDT_ADDR_CSR, 8'h40);
        rd(WDT_ADDR_CSR, 8'hEA);
        // random loads kept below 0x80 so the later run cannot overflow
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            v = seed & 8'h7F;
            wr(WDT_ADDR_CNT, v);
            rd(WDT_ADDR_CNT, v);
        end
        wr(WDT_ADDR_CSR, 8'hA4);
        rd(WDT_ADDR_CSR, 8'hEA);
        wr(WDT_ADDR_CSR, 8'h9A);
        rd(WDT_ADDR_CSR, 8'hFA);
        // run set while halted: count must hold still, register takes the write
        halt_mode <= 1'b1;
        wr(WDT_ADDR_CSR, 8'hA6);
        repeat (40) @(posedge pclk);
        rd(WDT_ADDR_CNT, v);
        rd(WDT_ADDR_CSR, 8'hFE);
        // about 28 running cycles leave a margin of 4 around three ticks
        halt_mode <= 1'b0;
        wr(WDT_ADDR_CNT, v);
        repeat (25) @(posedge pclk);
        wr(WDT_ADDR_CSR, 8'hA2);
        rd(WDT_ADDR_CNT, v + 8'h3);
        repeat (30) @(posedge pclk);
        rd(WDT_ADDR_CNT, v + 8'h3);
        rd(WDT_ADDR_CSR, 8'hFA);
        // overflow two ticks after loading 0xFE
        wr(WDT_ADDR_CSR, 8'hA6);
        wr(WDT_ADDR_CNT, 8'hFE);
        cnt = 0;
        while (wdt_reset_n !== 1'b0 && cnt < 60) begin
            @(posedge pclk);
            cnt++;
        end
        `CHK(wdt_reset_n, 1'b0)
        cnt = 0;
        while (wdt_reset_n === 1'b0 && cnt < 100) begin
            @(posedge pclk);
            cnt++;
        end
        `CHK(cnt, RC)
        rd(WDT_ADDR_CSR, 8'hAB);
        rd(WDT_ADDR_CNT, 8'h00);
        wr(WDT_ADDR_CSR, 8'h90);
        rd(WDT_ADDR_CSR, 8'hBB);
        wr(WDT_ADDR_CSR, 8'hAA);
        rd(WDT_ADDR_CSR, 8'hBB);
        wr(WDT_ADDR_CSR, 8'hA8);
        rd(WDT_ADDR_CSR, 8'hBA);
        // second overflow, cut short by the pin reset in mid-pulse
        wr(WDT_ADDR_CSR, 8'h54);
        wr(WDT_ADDR_CNT, WDT_CNT_MAX);
        cnt = 0;
        while (wdt_reset_n !== 1'b0 && cnt < 60) begin
            @(posedge pclk);
            cnt++;
        end
        `CHK(wdt_reset_n, 1'b0)
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK(wdt_reset_n, 1'b1)
        rd(WDT_ADDR_CSR, WDT_CSR_RESET);
        rd(WDT_ADDR_CNT, WDT_CNT_RESET);
        wrap_up();
    end
endmodule // tb
